// >>> pkg/lscr_pkg.sv
package lscr_pkg;

  // register addresses on the two address bits of a frame
  localparam logic [1:0] LSCR_ADDR_STATUS = 2'h0;
  localparam logic [1:0] LSCR_ADDR_CONFIG = 2'h1;

  // status register bit positions
  localparam int LSCR_ST_OVERHEAT    = 0;
  localparam int LSCR_ST_SUPPLY_LOW  = 1;
  localparam int LSCR_ST_REG_UV      = 2;
  localparam int LSCR_ST_LINE_FAULT  = 3;
  localparam int LSCR_ST_LINE_INV    = 4;
  localparam int LSCR_ST_DIGITAL_LVL = 5;

  // line configuration register bit positions
  localparam int LSCR_CF_RX_DISABLE  = 1;
  localparam int LSCR_CF_SW_LEVEL    = 2;
  localparam int LSCR_CF_DRV_ENABLE  = 3;
  localparam int LSCR_CF_PUSHPULL    = 4;
  localparam int LSCR_CF_LOWSIDE     = 5;
  localparam int LSCR_CF_FILTER      = 7;
  localparam logic [7:0] LSCR_CONFIG_RESET = 8'h00;
  localparam logic [7:0] LSCR_CONFIG_MASK  = 8'hbe;

  // serial frame: command byte then data byte, msb first
  localparam int LSCR_CMD_BITS   = 8;
  localparam int LSCR_FRAME_BITS = 16;
  localparam int LSCR_CMD_READ   = 7;
  localparam int LSCR_CMD_ADDR_HI = 6;
  localparam int LSCR_CMD_ADDR_LO = 5;
  localparam logic [4:0] LSCR_CNT_CMD   = 5'h08;
  localparam logic [4:0] LSCR_CNT_FRAME = 5'h10;

  // positions of the pin inputs in the synchroniser vector
  localparam int LSCR_IN_SCLK      = 0;
  localparam int LSCR_IN_CS_N      = 1;
  localparam int LSCR_IN_SDI       = 2;
  localparam int LSCR_IN_LINE      = 3;
  localparam int LSCR_IN_DIGITAL   = 4;
  localparam int LSCR_IN_FAULT     = 5;
  localparam int LSCR_IN_REG_UV    = 6;
  localparam int LSCR_IN_SUPPLY_UV = 7;
  localparam int LSCR_IN_HOT       = 8;
  localparam int LSCR_IN_COOL      = 9;
  localparam int LSCR_IN_TRANSMIT_ENABLE_PIN      = 10;
  localparam int LSCR_IN_TX        = 11;
  localparam int LSCR_IN_PP_PIN    = 12;
  localparam int LSCR_IN_LS_PIN    = 13;
  localparam int LSCR_IN_IF_SEL    = 14;
  localparam int LSCR_IN_COUNT     = 15;
  localparam logic [LSCR_IN_COUNT-1:0] LSCR_IN_RESET = 15'h0002;

  typedef struct packed {
    logic [LSCR_IN_COUNT-1:0] s1;
    logic [LSCR_IN_COUNT-1:0] s2;
    logic [LSCR_IN_COUNT-1:0] s3;
    logic [LSCR_IN_COUNT-1:0] filt;
    logic [7:0]               config_r;
    logic                     line_fault_flag;
    logic                     regulator_undervoltage_flag;
    logic                     supply_low_flag;
    logic                     overheat_flag;
    logic                     overheat_armed;
    logic                     line_fault_state;
    logic                     supply_low_state;
    logic                     overheat_state;
    logic [4:0]               bit_cnt;
    logic [7:0]               shift_in;
    logic [7:0]               shift_out;
    logic                     rd_frame;
    logic [1:0]               addr;
    logic                     sdo;
    logic                     interrupt_out_n;
    logic                     undervoltage_out;
    logic                     receive_out;
    logic                     logic_input_out;
    logic                     driver_on;
    logic                     drive_level;
    logic                     pushpull;
    logic                     lowside;
    logic                     filter_select;
  } lscr_state_t;

endpackage

// >>> rtl/lscr_line_status_config.sv
`timescale 1ns/10ps
module lscr_line_status_config
  import lscr_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // serial register port
  input  wire logic serial_clk,
  input  wire logic serial_cs_n,
  input  wire logic serial_din,
  output logic      serial_dout,
  // analog comparator results and the regulator monitor enable
  input  wire logic line_high_in,
  input  wire logic digital_high_in,
  input  wire logic line_fault_in,
  input  wire logic regulator_low_in,
  input  wire logic supply_low_in,
  input  wire logic die_hot_in,
  input  wire logic die_cool_in,
  input  wire logic regulator_monitor_enable,
  // transmit and configuration pins
  input  wire logic transmit_enable_pin,
  input  wire logic transmit_in,
  input  wire logic line_pushpull_pin,
  input  wire logic line_lowside_pin,
  input  wire logic interface_select_pin,
  // status and control outputs
  output logic      interrupt_out_n,
  output logic      undervoltage_out,
  output logic      receive_out,
  output logic      logic_input_out,
  output logic      line_fault_state,
  output logic      supply_low_state,
  output logic      overheat_state,
  output logic      line_driver_on,
  output logic      line_drive_level,
  output logic      line_pushpull_select,
  output logic      line_lowside_select,
  output logic      filter_select
);
  import lscr_pkg::*;

  lscr_state_t st_reg;
  lscr_state_t st_next;

  logic [LSCR_IN_COUNT-1:0] pins;
  logic [LSCR_IN_COUNT-1:0] filt_next;

  assign pins[LSCR_IN_SCLK]      = serial_clk;
  assign pins[LSCR_IN_CS_N]      = serial_cs_n;
  assign pins[LSCR_IN_SDI]       = serial_din;
  assign pins[LSCR_IN_LINE]      = line_high_in;
  assign pins[LSCR_IN_DIGITAL]   = digital_high_in;
  assign pins[LSCR_IN_FAULT]     = line_fault_in;
  assign pins[LSCR_IN_REG_UV]    = regulator_low_in;
  assign pins[LSCR_IN_SUPPLY_UV] = supply_low_in;
  assign pins[LSCR_IN_HOT]       = die_hot_in;
  assign pins[LSCR_IN_COOL]      = die_cool_in;
  assign pins[LSCR_IN_TRANSMIT_ENABLE_PIN]      = transmit_enable_pin;
  assign pins[LSCR_IN_TX]        = transmit_in;
  assign pins[LSCR_IN_PP_PIN]    = line_pushpull_pin;
  assign pins[LSCR_IN_LS_PIN]    = line_lowside_pin;
  assign pins[LSCR_IN_IF_SEL]    = interface_select_pin;

  // a pin change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < LSCR_IN_COUNT; gi = gi + 1) begin : g_sync
      assign filt_next[gi] = (st_reg.s2[gi] == st_reg.s3[gi]) ?
                             st_reg.s3[gi] : st_reg.filt[gi];
    end
  endgenerate

  logic sclk_rise;
  logic sclk_fall;
  logic frame_on;
  logic serial_mode;
  logic status_read;
  logic [7:0] status_word;
  logic [7:0] cfg_eff;
  logic [7:0] cmd;
  logic irq_any;
  // frame milestones
  logic cmd_done;
  logic data_done;
  logic sdo_step;
  // set and clear terms of the sticky flags
  logic fault_set;
  logic reg_uv_set;
  logic supply_set;
  logic hot_set;
  logic read_clear;
  // interrupt sources, regulator one gated by its monitor enable
  logic irq_fault;
  logic irq_supply;
  logic irq_hot;
  logic irq_reg_uv;
  // effective line configuration after the pin mode override
  logic eff_rx_disable;
  logic eff_sw_level;
  logic eff_drv_enable;
  logic eff_pushpull;
  logic eff_lowside;
  logic eff_filter;


  always_comb begin
    st_next      = st_reg;
    st_next.s1   = pins;
    st_next.s2   = st_reg.s1;
    st_next.s3   = st_reg.s2;
    st_next.filt = filt_next;

    serial_mode = st_reg.filt[LSCR_IN_IF_SEL];
    frame_on    = ~st_reg.filt[LSCR_IN_CS_N] & serial_mode;
    sclk_rise   = filt_next[LSCR_IN_SCLK] & ~st_reg.filt[LSCR_IN_SCLK];
    sclk_fall   = ~filt_next[LSCR_IN_SCLK] & st_reg.filt[LSCR_IN_SCLK];
    cmd         = {st_reg.shift_in[6:0], st_reg.filt[LSCR_IN_SDI]};

    // milestones of the 16-bit frame
    cmd_done    = frame_on & sclk_rise &
                  (st_reg.bit_cnt == LSCR_CNT_CMD - 5'h01);
    data_done   = frame_on & sclk_rise &
                  (st_reg.bit_cnt == LSCR_CNT_FRAME - 5'h01);
    sdo_step    = frame_on & sclk_fall & (st_reg.bit_cnt >= LSCR_CNT_CMD);

    status_word = 8'h00;
    status_word[LSCR_ST_OVERHEAT]    = st_reg.overheat_flag;
    status_word[LSCR_ST_SUPPLY_LOW]  = st_reg.supply_low_flag;
    status_word[LSCR_ST_REG_UV]      = st_reg.regulator_undervoltage_flag;
    status_word[LSCR_ST_LINE_FAULT]  = st_reg.line_fault_flag;
    status_word[LSCR_ST_LINE_INV]    = ~st_reg.filt[LSCR_IN_LINE];
    status_word[LSCR_ST_DIGITAL_LVL] = st_reg.filt[LSCR_IN_DIGITAL];

    // serial framing: sample on rising edge, shift out on falling edge
    // a frame cut short drops its write; bits past sixteen are ignored
    status_read = 1'b0;
    if (!frame_on) begin
      st_next.bit_cnt   = 5'h00;
      st_next.rd_frame  = 1'b0;
      st_next.shift_out = 8'h00;
    end else begin
      if (sclk_rise && st_reg.bit_cnt != LSCR_CNT_FRAME) begin
        st_next.shift_in = cmd;
        st_next.bit_cnt  = st_reg.bit_cnt + 5'h01;
        if (cmd_done) begin
          st_next.rd_frame = cmd[LSCR_CMD_READ];
          st_next.addr     = cmd[LSCR_CMD_ADDR_HI:LSCR_CMD_ADDR_LO];
          if (cmd[LSCR_CMD_READ]) begin
            case (cmd[LSCR_CMD_ADDR_HI:LSCR_CMD_ADDR_LO])
              LSCR_ADDR_STATUS: begin
                st_next.shift_out = status_word;
                status_read       = 1'b1;
              end
              LSCR_ADDR_CONFIG: st_next.shift_out = st_reg.config_r;
              default:          st_next.shift_out = 8'h00;
            endcase
          end
        end
        if (data_done && !st_reg.rd_frame &&
            st_reg.addr == LSCR_ADDR_CONFIG) begin
          st_next.config_r = cmd & LSCR_CONFIG_MASK;
        end
      end
      if (sdo_step) begin
        st_next.sdo       = st_reg.shift_out[7];
        st_next.shift_out = {st_reg.shift_out[6:0], 1'b0};
      end
    end
    if (!frame_on) begin
      st_next.sdo = 1'b0;
    end

    // fault and supply state bits follow their detectors; overheat state sets on hot, clears on cool
    st_next.line_fault_state = st_reg.filt[LSCR_IN_FAULT];
    st_next.supply_low_state = st_reg.filt[LSCR_IN_SUPPLY_UV];
    if (st_reg.filt[LSCR_IN_HOT]) begin
      st_next.overheat_state = 1'b1;
    end else if (st_reg.filt[LSCR_IN_COOL]) begin
      st_next.overheat_state = 1'b0;
    end

    // set terms come straight from the synchronised detectors, except hot_set: overheat_state gated by overheat_armed
    fault_set  = st_reg.filt[LSCR_IN_FAULT];
    reg_uv_set = st_reg.filt[LSCR_IN_REG_UV];
    supply_set = st_reg.filt[LSCR_IN_SUPPLY_UV];
    hot_set    = st_reg.overheat_state & st_reg.overheat_armed;
    read_clear = status_read;

    // set wins over a read clear so a persisting fault stays visible
    if (fault_set) begin
      st_next.line_fault_flag = 1'b1;
    end else if (read_clear) begin
      st_next.line_fault_flag = 1'b0;
    end
    if (reg_uv_set) begin
      st_next.regulator_undervoltage_flag = 1'b1;
    end else if (read_clear) begin
      st_next.regulator_undervoltage_flag = 1'b0;
    end
    if (supply_set) begin
      st_next.supply_low_flag = 1'b1;
    end else if (read_clear) begin
      st_next.supply_low_flag = 1'b0;
    end

    // a read disarms only once it has shown the overheat flag, so a
    // warning that rises in the read cycle is not lost; the flag then
    // stays down until the die has cooled
    if (!st_reg.overheat_state) begin
      st_next.overheat_armed = 1'b1;
    end else if (read_clear && st_reg.overheat_flag) begin
      st_next.overheat_armed = 1'b0;
    end
    if (read_clear && st_reg.overheat_flag) begin
      st_next.overheat_flag = 1'b0;
    end else if (hot_set) begin
      st_next.overheat_flag = 1'b1;
    end

    // monitor enable is a same-clock input, read without a synchroniser
    irq_fault  = st_next.line_fault_flag;
    irq_supply = st_next.supply_low_flag;
    irq_hot    = st_next.overheat_flag;
    irq_reg_uv = st_next.regulator_undervoltage_flag &
                 regulator_monitor_enable;
    irq_any    = irq_fault | irq_supply | irq_hot | irq_reg_uv;
    st_next.interrupt_out_n  = ~irq_any;
    st_next.undervoltage_out = regulator_monitor_enable &
                               st_next.regulator_undervoltage_flag &
                               st_reg.filt[LSCR_IN_REG_UV];

    // parallel pin mode overrides the configuration register
    if (serial_mode) begin
      cfg_eff = st_reg.config_r;
    end else begin
      cfg_eff = 8'h00;
      cfg_eff[LSCR_CF_PUSHPULL] = st_reg.filt[LSCR_IN_PP_PIN];
      cfg_eff[LSCR_CF_LOWSIDE]  = st_reg.filt[LSCR_IN_LS_PIN];
    end

    eff_rx_disable = cfg_eff[LSCR_CF_RX_DISABLE];
    eff_sw_level   = cfg_eff[LSCR_CF_SW_LEVEL];
    eff_drv_enable = cfg_eff[LSCR_CF_DRV_ENABLE];
    eff_pushpull   = cfg_eff[LSCR_CF_PUSHPULL];
    eff_lowside    = cfg_eff[LSCR_CF_LOWSIDE];
    eff_filter     = cfg_eff[LSCR_CF_FILTER];

    // the level bit in status keeps tracking while receive is forced
    st_next.receive_out = eff_rx_disable |
                          ~st_reg.filt[LSCR_IN_LINE];
    st_next.logic_input_out = ~st_reg.filt[LSCR_IN_DIGITAL];
    st_next.driver_on = st_reg.filt[LSCR_IN_TRANSMIT_ENABLE_PIN] |
                        eff_drv_enable;
    // with level bit 0 the tx pin alone sets the line
    st_next.drive_level = eff_sw_level |
                          ~st_reg.filt[LSCR_IN_TX];
    // topology only matters to the driver stage; both kept as set
    st_next.pushpull      = eff_pushpull;
    st_next.lowside       = eff_lowside;
    // one corner for line and digital receivers alike
    st_next.filter_select = eff_filter;

    // all fields spelled out so the reset image reads in one place
    if (reset) begin
      st_next.s1       = LSCR_IN_RESET;
      st_next.s2       = LSCR_IN_RESET;
      st_next.s3       = LSCR_IN_RESET;
      st_next.filt     = LSCR_IN_RESET;
      st_next.config_r = LSCR_CONFIG_RESET;
      st_next.line_fault_flag             = 1'b0;
      st_next.regulator_undervoltage_flag = 1'b0;
      st_next.supply_low_flag             = 1'b0;
      st_next.overheat_flag               = 1'b0;
      st_next.overheat_armed              = 1'b1;
      st_next.line_fault_state            = 1'b0;
      st_next.supply_low_state            = 1'b0;
      st_next.overheat_state              = 1'b0;
      st_next.bit_cnt                     = 5'h00;
      st_next.shift_in                    = 8'h00;
      st_next.shift_out                   = 8'h00;
      st_next.rd_frame                    = 1'b0;
      st_next.addr                        = 2'h0;
      st_next.sdo                         = 1'b0;
      st_next.interrupt_out_n             = 1'b1;
      st_next.undervoltage_out            = 1'b0;
      st_next.receive_out                 = 1'b1;
      st_next.logic_input_out             = 1'b1;
      st_next.driver_on                   = 1'b0;
      st_next.drive_level                 = 1'b1;
      st_next.pushpull                    = 1'b0;
      st_next.lowside                     = 1'b0;
      st_next.filter_select               = 1'b0;
    end
  end

  // one register stage holds the whole state
  always_ff @(posedge core_clk) begin
    st_reg <= st_next;
  end

  assign serial_dout          = st_reg.sdo;
  assign interrupt_out_n      = st_reg.interrupt_out_n;
  assign undervoltage_out     = st_reg.undervoltage_out;
  assign receive_out          = st_reg.receive_out;
  assign logic_input_out      = st_reg.logic_input_out;
  assign line_fault_state     = st_reg.line_fault_state;
  assign supply_low_state     = st_reg.supply_low_state;
  assign overheat_state       = st_reg.overheat_state;
  assign line_driver_on       = st_reg.driver_on;
  assign line_drive_level     = st_reg.drive_level;
  assign line_pushpull_select = st_reg.pushpull;
  assign line_lowside_select  = st_reg.lowside;
  assign filter_select        = st_reg.filter_select;

endmodule

// >>> verification/lscr_checker_assertions.sv
`timescale 1ns/10ps
module lscr_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // pins
  input wire logic line_high_in,
  input wire logic digital_high_in,
  input wire logic line_fault_in,
  input wire logic regulator_low_in,
  input wire logic supply_low_in,
  input wire logic regulator_monitor_enable,
  input wire logic transmit_enable_pin,
  // outputs
  input wire logic interrupt_out_n,
  input wire logic undervoltage_out,
  input wire logic receive_out,
  input wire logic logic_input_out,
  input wire logic line_fault_state,
  input wire logic supply_low_state,
  input wire logic overheat_state,
  input wire logic line_driver_on
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // eight cycles outlast the synchroniser
  sequence s_line_lo; !line_high_in [*8]; endsequence
  sequence s_dig_hi; digital_high_in [*8]; endsequence
  sequence s_dig_lo; !digital_high_in [*8]; endsequence
  sequence s_fault; line_fault_in [*8]; endsequence
  sequence s_supply; supply_low_in [*8]; endsequence
  property p_rx; s_line_lo |-> ##[0:3] receive_out; endproperty
  a_rx: assert property (p_rx) else $error("rx low");
  property p_li_lo; s_dig_hi |-> ##[0:3] !logic_input_out; endproperty
  a_li_lo: assert property (p_li_lo) else $error("li high");
  property p_li_hi; s_dig_lo |-> ##[0:3] logic_input_out; endproperty
  a_li_hi: assert property (p_li_hi) else $error("li low");
  property p_fault;
    s_fault |-> ##[0:3] (!interrupt_out_n && line_fault_state);
  endproperty
  a_fault: assert property (p_fault) else $error("fault irq");
  property p_supply;
    s_supply |-> ##[0:3] (!interrupt_out_n && supply_low_state);
  endproperty
  a_supply: assert property (p_supply) else $error("supply irq");
  property p_hot;
    $rose(overheat_state) |-> ##[1:3] !interrupt_out_n;
  endproperty
  a_hot: assert property (p_hot) else $error("hot irq");
  property p_uv_en;
    undervoltage_out |-> $past(regulator_monitor_enable);
  endproperty
  a_uv_en: assert property (p_uv_en) else $error("uv unmonitored");
  property p_uv_rel;
    !regulator_low_in [*8] |-> ##[0:3] !undervoltage_out;
  endproperty
  a_uv_rel: assert property (p_uv_rel) else $error("uv held");
  property p_drv;
    transmit_enable_pin [*8] |-> ##[0:3] line_driver_on;
  endproperty
  a_drv: assert property (p_drv) else $error("driver off");
endmodule
bind lscr_line_status_config lscr_checker i_chk (
  .core_clk, .reset, .line_high_in, .digital_high_in, .line_fault_in,
  .regulator_low_in, .supply_low_in, .regulator_monitor_enable,
  .transmit_enable_pin, .interrupt_out_n, .undervoltage_out,
  .receive_out, .logic_input_out, .line_fault_state, .supply_low_state,
  .overheat_state, .line_driver_on
);

// >>> verification/lscr_host_model.sv
`timescale 1ns/10ps
module lscr_host_model (
  // serial pins
  output logic      serial_clk,
  output logic      serial_cs_n,
  output logic      serial_din,
  input  wire logic serial_dout
);
  initial begin
    serial_clk = 1'b0;
    serial_cs_n = 1'b1;
    serial_din = 1'b0;
  end
  // command byte then data byte, msb first, 200 ns clock
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] fr;
    fr = {cmd, wd};
    rd = 8'h00;
    serial_cs_n = 1'b0;
    #200;
    for (int i = 15; i >= 0; i--) begin
      serial_din = fr[i];
      #100;
      if (i < 8) rd[i] = serial_dout;
      serial_clk = 1'b1;
      #100;
      serial_clk = 1'b0;
    end
    #100;
    serial_cs_n = 1'b1;
    // released line: no stale level to lean on
    serial_din = ~serial_din;
    #200;
  endtask
endmodule

// >>> verification/lscr_line_status_config_bench.sv
`timescale 1ns/10ps
module lscr_line_status_config_bench;
  import lscr_pkg::*;
  logic core_clk, reset, serial_clk, serial_cs_n, serial_din, serial_dout;
  logic line_high_in, digital_high_in, line_fault_in, regulator_low_in;
  logic supply_low_in, die_hot_in, die_cool_in, regulator_monitor_enable;
  logic transmit_enable_pin, transmit_in, line_pushpull_pin;
  logic line_lowside_pin, interface_select_pin, interrupt_out_n;
  logic undervoltage_out, receive_out, logic_input_out, line_fault_state;
  logic supply_low_state, overheat_state, line_driver_on, line_drive_level;
  logic line_pushpull_select, line_lowside_select, filter_select;
  int errors, compares;
  logic [7:0] rd;
  logic [7:0] cw [2] = '{8'h2c, 8'hd3};
  logic [7:0] co [2] = '{8'h3a, 8'hc6};
  logic [7:0] ev [4] = '{8'h02, 8'h04, 8'h00, 8'h08};
  lscr_host_model i_host (.serial_clk, .serial_cs_n, .serial_din,
    .serial_dout);
  lscr_line_status_config i_dut (.core_clk, .reset, .serial_clk,
    .serial_cs_n, .serial_din, .serial_dout, .line_high_in,
    .digital_high_in, .line_fault_in, .regulator_low_in, .supply_low_in,
    .die_hot_in, .die_cool_in, .regulator_monitor_enable,
    .transmit_enable_pin, .transmit_in, .line_pushpull_pin,
    .line_lowside_pin, .interface_select_pin, .interrupt_out_n,
    .undervoltage_out, .receive_out, .logic_input_out, .line_fault_state,
    .supply_low_state, .overheat_state, .line_driver_on, .line_drive_level,
    .line_pushpull_select, .line_lowside_select, .filter_select);
  function automatic logic [7:0] ctl();
    return {filter_select, line_pushpull_select, line_lowside_select,
      line_driver_on, line_drive_level, receive_out, logic_input_out,
      undervoltage_out};
  endfunction
  function automatic logic [7:0] evt();
    return {4'h0, line_fault_state, supply_low_state, overheat_state,
      interrupt_out_n};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] unused;
    i_host.xfer({1'b0, a, 5'h00}, d, unused);
    tick(4);
  endtask
  task automatic rdr(input logic [1:0] a, output logic [7:0] d);
    i_host.xfer({1'b1, a, 5'h00}, 8'h00, d);
    tick(4);
  endtask
  task automatic set_src(input int b, input logic v);
    case (b)
      3: line_fault_in = v;
      2: regulator_low_in = v;
      1: supply_low_in = v;
      default: die_hot_in = v;
    endcase
    tick(12);
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    print_verdict();
  end
  initial begin
    {line_high_in, digital_high_in, line_fault_in, regulator_low_in} = 4'h0;
    {supply_low_in, die_hot_in, die_cool_in, transmit_in} = 4'h0;
    {transmit_enable_pin, line_pushpull_pin, line_lowside_pin} = 3'h0;
    {regulator_monitor_enable, interface_select_pin, reset} = 3'h7;
    errors = 0;
    compares = 0;
    tick(20);
    reset = 1'b0;
    tick(6);
    check(ctl(), 8'h0e);
    rdr(LSCR_ADDR_STATUS, rd);
    check(rd, 8'h10);
    rdr(LSCR_ADDR_CONFIG, rd);
    check(rd, LSCR_CONFIG_RESET);
    line_high_in = 1'b1;
    transmit_in = 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(LSCR_ADDR_CONFIG, cw[i]);
      rdr(LSCR_ADDR_CONFIG, rd);
      check(rd, cw[i] & LSCR_CONFIG_MASK);
      check(ctl(), co[i]);
      rdr(LSCR_ADDR_STATUS, rd);
      check(rd, 8'h00);
    end
    transmit_enable_pin = 1'b1;
    transmit_in = 1'b0;
    tick(8);
    check(ctl(), 8'hde);
    wr(LSCR_ADDR_CONFIG, 8'h00);
    transmit_enable_pin = 1'b0;
    digital_high_in = 1'b1;
    tick(8);
    check(ctl(), 8'h08);
    for (int b = 3; b >= 0; b--) begin
      set_src(b, 1'b1);
      check(evt(), ev[b]);
      check({7'h00, undervoltage_out}, {7'h00, b == 2});
      rdr(LSCR_ADDR_STATUS, rd);
      check(rd, 8'h20 | (8'h01 << b));
      set_src(b, 1'b0);
      check(ctl(), 8'h08);
      rdr(LSCR_ADDR_STATUS, rd);
      check(rd, b == 0 ? 8'h20 : 8'h20 | (8'h01 << b));
      rdr(LSCR_ADDR_STATUS, rd);
      check(rd, 8'h20);
      check(evt(), b == 0 ? 8'h03 : 8'h01);
    end
    die_cool_in = 1'b1;
    tick(8);
    die_cool_in = 1'b0;
    set_src(0, 1'b1);
    rdr(LSCR_ADDR_STATUS, rd);
    check(rd, 8'h21);
    die_cool_in = 1'b1;
    regulator_monitor_enable = 1'b0;
    set_src(0, 1'b0);
    set_src(2, 1'b1);
    check(evt(), 8'h01);
    check(ctl(), 8'h08);
    rdr(LSCR_ADDR_STATUS, rd);
    check(rd, 8'h24);
    set_src(2, 1'b0);
    rdr(2'h2, rd);
    check(rd, 8'h00);
    interface_select_pin = 1'b0;
    line_pushpull_pin = 1'b1;
    line_lowside_pin = 1'b1;
    wr(LSCR_ADDR_CONFIG, 8'h80);
    check(ctl(), 8'h68);
    interface_select_pin = 1'b1;
    tick(8);
    rdr(LSCR_ADDR_CONFIG, rd);
    check(rd, LSCR_CONFIG_RESET);
    print_verdict();
  end
endmodule
